//--- hw/clk_gate_pkg.sv
// Package of offsets, field layouts, reset values and types of the gating block.
package clk_gate_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int          ADDR_W            = 12;
   localparam int          DATA_W            = 32;
   localparam logic [11:0] RUN_ZERO_OFF      = 12'h100;
   localparam logic [11:0] RUN_ONE_OFF       = 12'h104;
   localparam logic [11:0] SLEEP_ZERO_OFF    = 12'h110;
   localparam logic [11:0] SLEEP_ONE_OFF     = 12'h114;
   localparam logic [11:0] DEEP_ZERO_OFF     = 12'h120;
   localparam logic [11:0] DEEP_ONE_OFF      = 12'h124;
   localparam logic [11:0] CLK_CFG_OFF       = 12'h140;
   localparam logic [11:0] IRQ_STATUS_OFF    = 12'h144;
   localparam logic [11:0] IRQ_MASK_OFF      = 12'h148;
   localparam logic [11:0] FAULT_UNIT_OFF    = 12'h14c;

   // ****************************************************************
   // Field positions, writable masks and reset values
   // ****************************************************************
   localparam int          CAN_BIT           = 24;
   localparam int          HIB_BIT           = 6;
   localparam int          WDT_BIT           = 3;
   localparam int          TIMER_LSB         = 16;
   localparam int          TIMER_CNT         = 4;
   localparam int          AUTO_SEL_BIT      = 0;
   localparam int          FAULT_EV_BIT      = 0;
   localparam int          UNMAPPED_EV_BIT   = 1;
   localparam int          EVENT_W           = 2;
   localparam logic [31:0] ZERO_WR_MASK      = 32'h0100_0048;
   localparam logic [31:0] ONE_WR_MASK       = 32'h000f_0000;
   localparam logic [31:0] ZERO_RESET        = 32'h0000_0040;
   localparam logic [31:0] ONE_RESET         = 32'h0000_0000;
   localparam logic [31:0] CFG_WR_MASK       = 32'h0000_0001;
   localparam logic [31:0] CFG_RESET         = 32'h0000_0000;

   // ****************************************************************
   // Peripheral units, in the order of the clock enable vector
   // ****************************************************************
   localparam int          UNIT_CNT          = 7;
   localparam logic [2:0]  UNIT_CAN          = 3'h0;
   localparam logic [2:0]  UNIT_HIB          = 3'h1;
   localparam logic [2:0]  UNIT_WDT          = 3'h2;
   localparam logic [2:0]  UNIT_GENERAL_TIMER_ZERO_GATE       = 3'h3;

   // Power mode of the system, one-hot.
   typedef enum logic [2:0] {
      MODE_RUN   = 3'b001,
      MODE_SLEEP = 3'b010,
      MODE_DEEP  = 3'b100
   } power_mode_e;

   // One register bus request.
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;

   // One access by the system bus to a peripheral unit.
   typedef struct packed {
      logic        valid;
      logic [2:0]  unit;
   } periph_access_s;

endpackage

//--- hw/gate_field.sv
// Holds one 32-bit gating register with a writable-bit mask.
`timescale 1ns/1ps

module gate_field #(
   parameter logic [31:0] RESET_VAL = 32'h0000_0000,
   parameter logic [31:0] WR_MASK   = 32'h0000_0000
) (
   // Clock and reset.
   input  wire logic        mclk_in,
   input  wire logic        reset_n_in,
   // Write port.
   input  wire logic        wr_in,
   input  wire logic [31:0] wdata_in,
   // Stored value.
   output logic      [31:0] value_out
);

   // Only writable bits take the write data; reserved bits stay zero.
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         value_out <= RESET_VAL & WR_MASK; // [RL14]
      end else if (wr_in) begin
         value_out <= (wdata_in & WR_MASK) | (value_out & ~WR_MASK); // [RL15]
      end
   end

endmodule // gate_field

//--- hw/periph_clock_gating.sv
// Peripheral clock gating registers, mode selection and bus fault check.
`timescale 1ns/1ps

// Functional notes
// (RL1) Set gate bit delivers unit clock.
// (RL2) Clear gate bit stops unit clock.
// (RL3) Access to unclocked unit raises fault.
// (RL4) Gate bits reset to zero unless noted.
// (RL5) Software enables needed units before use.
// (RL6) Separate run, sleep, deep-sleep gate sets.
// (RL7) Sleep sets apply only with auto select.
// (RL8) Deep-sleep reg zero 0x120, reset 0x40.
// (RL9) Run reg one 0x104, resets to zero.
// (RL10) Bit 24 gates network controller unit.
// (RL11) Bit 6 gates hibernation, resets one.
// (RL12) Bit 3 gates watchdog, resets zero.
// (RL13) Bits 19..16 gate timers three..zero.
// (RL14) Reserved bits read zero, read-only.
// (RL15) Writes to reserved bits are ignored.
module periph_clock_gating
   import clk_gate_pkg::*;
#(
   parameter int N_UNITS = UNIT_CNT
) (
   // Clock and reset.
   input  wire logic                 mclk_in,
   input  wire logic                 reset_n_in,
   // Register port.
   input  wire reg_req_s             reg_req_in,
   output logic [DATA_W-1:0]         reg_rdata_out,
   // Power mode requests from the processor.
   input  wire logic                 sleep_in,
   input  wire logic                 deep_sleep_in,
   // Peripheral accesses and their outcome.
   input  wire periph_access_s       periph_access_in,
   output logic                      periph_fault_out,
   // Clock enables, one per unit.
   output logic [N_UNITS-1:0]        unit_clk_en_out,
   // Interrupt.
   output logic                      irq_out
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Maps a register-zero and register-one pair onto the unit vector.
   function automatic logic [N_UNITS-1:0] unit_enables(
      input logic [31:0] zero_reg,
      input logic [31:0] one_reg
   );
      logic [N_UNITS-1:0] en;
      en = '0;
      en[UNIT_CAN] = zero_reg[CAN_BIT]; // [RL10]
      en[UNIT_HIB] = zero_reg[HIB_BIT]; // [RL11]
      en[UNIT_WDT] = zero_reg[WDT_BIT]; // [RL12]
      for (int i = 0; i < TIMER_CNT; i++) begin
         en[int'(UNIT_GENERAL_TIMER_ZERO_GATE) + i] = one_reg[TIMER_LSB + i]; // [RL13]
      end
      return en;
   endfunction

   // Decodes a write strobe for one register offset.
   function automatic logic wr_hit(
      input reg_req_s   req,
      input logic [11:0] off
   );
      return req.wr && (req.addr == off);
   endfunction

   // ****************************************************************
   // Gating register sets
   // ****************************************************************
   logic [31:0]       run_zero_q;
   logic [31:0]       run_one_q;
   logic [31:0]       sleep_zero_q;
   logic [31:0]       sleep_one_q;
   logic [31:0]       deep_zero_q;
   logic [31:0]       deep_one_q;
   logic [31:0]       clk_cfg_q;

   // Run set, register zero.
   gate_field #(.RESET_VAL(ZERO_RESET), .WR_MASK(ZERO_WR_MASK)) u_run_zero (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .wr_in      (wr_hit(reg_req_in, RUN_ZERO_OFF)),
      .wdata_in   (reg_req_in.wdata),
      .value_out  (run_zero_q)
   );

   // Run set, register one; timers reset unclocked. [RL9] [RL13]
   gate_field #(.RESET_VAL(ONE_RESET), .WR_MASK(ONE_WR_MASK)) u_run_one (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .wr_in      (wr_hit(reg_req_in, RUN_ONE_OFF)),
      .wdata_in   (reg_req_in.wdata),
      .value_out  (run_one_q)
   );

   // Sleep set, register zero. [RL6]
   gate_field #(.RESET_VAL(ZERO_RESET), .WR_MASK(ZERO_WR_MASK)) u_slp_zero (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .wr_in      (wr_hit(reg_req_in, SLEEP_ZERO_OFF)),
      .wdata_in   (reg_req_in.wdata),
      .value_out  (sleep_zero_q)
   );

   // Sleep set, register one.
   gate_field #(.RESET_VAL(ONE_RESET), .WR_MASK(ONE_WR_MASK)) u_slp_one (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .wr_in      (wr_hit(reg_req_in, SLEEP_ONE_OFF)),
      .wdata_in   (reg_req_in.wdata),
      .value_out  (sleep_one_q)
   );

   // Deep-sleep set, register zero; hibernation clocked at reset.
   gate_field #(.RESET_VAL(ZERO_RESET), .WR_MASK(ZERO_WR_MASK)) u_deep_zero (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .wr_in      (wr_hit(reg_req_in, DEEP_ZERO_OFF)), // [RL8]
      .wdata_in   (reg_req_in.wdata),
      .value_out  (deep_zero_q)
   );

   // Deep-sleep set, register one.
   gate_field #(.RESET_VAL(ONE_RESET), .WR_MASK(ONE_WR_MASK)) u_deep_one (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .wr_in      (wr_hit(reg_req_in, DEEP_ONE_OFF)),
      .wdata_in   (reg_req_in.wdata),
      .value_out  (deep_one_q)
   );

   // Clock configuration holding the automatic gating select.
   gate_field #(.RESET_VAL(CFG_RESET), .WR_MASK(CFG_WR_MASK)) u_clk_cfg (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .wr_in      (wr_hit(reg_req_in, CLK_CFG_OFF)),
      .wdata_in   (reg_req_in.wdata),
      .value_out  (clk_cfg_q)
   );

   // ****************************************************************
   // Mode selection and clock enables
   // ****************************************************************
   power_mode_e        mode_q;
   logic [N_UNITS-1:0] clk_en_d;
   logic               auto_sel;

   assign auto_sel = clk_cfg_q[AUTO_SEL_BIT];

   // Tracks the power mode; deep sleep outranks sleep.
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         mode_q <= MODE_RUN;
      end else if (deep_sleep_in) begin
         mode_q <= MODE_DEEP;
      end else if (sleep_in) begin
         mode_q <= MODE_SLEEP;
      end else begin
         mode_q <= MODE_RUN;
      end
   end

   // Picks the governing set; without auto select the run set rules.
   always_comb begin
      case (mode_q)
         MODE_SLEEP: begin
            clk_en_d = auto_sel ? unit_enables(sleep_zero_q, sleep_one_q)
                                : unit_enables(run_zero_q, run_one_q); // [RL7]
         end
         MODE_DEEP: begin
            clk_en_d = auto_sel ? unit_enables(deep_zero_q, deep_one_q)
                                : unit_enables(run_zero_q, run_one_q); // [RL7]
         end
         default: begin
            clk_en_d = unit_enables(run_zero_q, run_one_q); // [RL6]
         end
      endcase
   end

   // Drives each unit clock enable: one clocks, zero stops. [RL1] [RL2]
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         unit_clk_en_out <= '0; // [RL4]
      end else begin
         unit_clk_en_out <= clk_en_d;
      end
   end

   // ****************************************************************
   // Bus fault on accesses to unclocked units
   // ****************************************************************
   logic               fault_d;
   logic [2:0]         fault_unit_q;

   // The software should enable units before use; otherwise it faults.
   assign fault_d = periph_access_in.valid &&
                    ((int'(periph_access_in.unit) >= N_UNITS) ||
                     !unit_clk_en_out[periph_access_in.unit]); // [RL3] [RL5]

   // Answers the access with a one-cycle fault pulse.
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         periph_fault_out <= 1'b0;
      end else begin
         periph_fault_out <= fault_d; // [RL3] [RL12]
      end
   end

   // Records which unit faulted last.
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         fault_unit_q <= 3'h0;
      end else if (fault_d) begin
         fault_unit_q <= periph_access_in.unit;
      end
   end

   // ****************************************************************
   // Interrupt status and mask
   // ****************************************************************
   logic [EVENT_W-1:0] irq_status_q;
   logic [EVENT_W-1:0] irq_mask_q;
   logic [EVENT_W-1:0] event_set;
   logic [EVENT_W-1:0] event_clr;
   logic               reg_hit;

   // Any mapped register offset.
   always_comb begin
      case (reg_req_in.addr)
         RUN_ZERO_OFF, RUN_ONE_OFF, SLEEP_ZERO_OFF, SLEEP_ONE_OFF,
         DEEP_ZERO_OFF, DEEP_ONE_OFF, CLK_CFG_OFF, IRQ_STATUS_OFF,
         IRQ_MASK_OFF, FAULT_UNIT_OFF: begin
            reg_hit = 1'b1;
         end
         default: begin
            reg_hit = 1'b0;
         end
      endcase
   end

   assign event_set[FAULT_EV_BIT]    = fault_d;
   assign event_set[UNMAPPED_EV_BIT] = (reg_req_in.wr || reg_req_in.rd)
                                       && !reg_hit;
   assign event_clr = wr_hit(reg_req_in, IRQ_STATUS_OFF)
                      ? reg_req_in.wdata[EVENT_W-1:0] : '0;

   // Sticky status, write one to clear; a new event beats the clear.
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         irq_status_q <= '0;
      end else begin
         irq_status_q <= (irq_status_q & ~event_clr) | event_set;
      end
   end

   // Interrupt mask.
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         irq_mask_q <= '0;
      end else if (wr_hit(reg_req_in, IRQ_MASK_OFF)) begin
         irq_mask_q <= reg_req_in.wdata[EVENT_W-1:0];
      end
   end

   // Level interrupt, one cycle behind the status.
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_status_q & irq_mask_q);
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [31:0]        rdata_d;

   // Selects read data; reserved and unmapped bits read zero. [RL14]
   always_comb begin
      case (reg_req_in.addr)
         RUN_ZERO_OFF:   rdata_d = run_zero_q;
         RUN_ONE_OFF:    rdata_d = run_one_q;
         SLEEP_ZERO_OFF: rdata_d = sleep_zero_q;
         SLEEP_ONE_OFF:  rdata_d = sleep_one_q;
         DEEP_ZERO_OFF:  rdata_d = deep_zero_q;
         DEEP_ONE_OFF:   rdata_d = deep_one_q;
         CLK_CFG_OFF:    rdata_d = clk_cfg_q;
         IRQ_STATUS_OFF: rdata_d = {{(32-EVENT_W){1'b0}}, irq_status_q};
         IRQ_MASK_OFF:   rdata_d = {{(32-EVENT_W){1'b0}}, irq_mask_q};
         FAULT_UNIT_OFF: rdata_d = {29'h0, fault_unit_q};
         default:        rdata_d = 32'h0000_0000;
      endcase
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= '0;
      end else if (reg_req_in.rd) begin
         reg_rdata_out <= rdata_d;
      end else begin
         reg_rdata_out <= '0;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);

   logic rst_seen_q;

   // Marks the first cycle after reset release.
   always_ff @(posedge mclk_in) begin
      rst_seen_q <= !reset_n_in;
   end

   deep_reset_a: assert property ( // [RL8]
      rst_seen_q |-> deep_zero_q == 32'h0000_0040)
      else $error("deep-sleep register zero reset value wrong");

   run_reset_a: assert property ( // [RL9]
      rst_seen_q |-> run_one_q == 32'h0000_0000 && unit_clk_en_out == '0)
      else $error("run register one or enables not reset");

   hib_default_a: assert property ( // [RL11]
      rst_seen_q |-> deep_zero_q[6] && !deep_zero_q[3] && !deep_zero_q[24])
      else $error("deep-sleep gate bits reset wrong");

   reserved_zero_a: assert property ( // [RL14]
      (deep_zero_q & 32'hfeff_ffb7) == '0 && (run_one_q & 32'hfff0_ffff) == '0)
      else $error("reserved gate bits not zero");

   reserved_write_a: assert property ( // [RL15]
      reg_req_in.wr && reg_req_in.addr == 12'h120
      |=> deep_zero_q == ($past(reg_req_in.wdata) & 32'h0100_0048))
      else $error("deep-sleep write not masked");

   timer_write_a: assert property ( // [RL13]
      reg_req_in.wr && reg_req_in.addr == 12'h104 ##1 mode_q == MODE_RUN
      |=> unit_clk_en_out[6:3] == $past(reg_req_in.wdata[19:16], 2))
      else $error("timer gates do not follow run register one");

   fault_pulse_a: assert property ( // [RL3]
      periph_access_in.valid && !unit_clk_en_out[periph_access_in.unit]
      |=> periph_fault_out)
      else $error("access to unclocked unit did not fault");

   no_fault_a: assert property ( // [RL1]
      periph_access_in.valid && periph_access_in.unit < 3'h7 &&
      unit_clk_en_out[periph_access_in.unit] |=> !periph_fault_out)
      else $error("access to clocked unit faulted");

   wdt_fault_a: assert property ( // [RL12]
      periph_access_in.valid && periph_access_in.unit == 3'h2 &&
      !unit_clk_en_out[2] |=> periph_fault_out && irq_status_q[0])
      else $error("gated watchdog access did not fault");

   run_governs_a: assert property ( // [RL7]
      !clk_cfg_q[0] ##1 !clk_cfg_q[0]
      |=> unit_clk_en_out == $past(unit_enables(run_zero_q, run_one_q)))
      else $error("run set not governing without auto select");

   gate_off_a: assert property ( // [RL2]
      mode_q == MODE_DEEP && clk_cfg_q[0] && !deep_zero_q[6]
      |=> !unit_clk_en_out[1])
      else $error("hibernation clock not stopped");

   sticky_a: assert property ( // [RL3]
      irq_status_q[0] && !event_clr[0] |=> irq_status_q[0])
      else $error("status bit lost without clear");

   deep_used_c: cover property (
      clk_cfg_q[0] && mode_q == MODE_DEEP ##1 unit_clk_en_out == 7'h41);
   fault_c: cover property (periph_fault_out ##1 irq_status_q[0]);
   irq_c: cover property (irq_out ##[1:4] !irq_out);
   sleep_c: cover property (clk_cfg_q[0] && mode_q == MODE_SLEEP);

endmodule // periph_clock_gating

//--- bench/periph_clock_gating_tb_top.sv
// Self-checking testbench of the peripheral clock gating block.
`timescale 1ns/1ps

module periph_clock_gating_tb_top;
   import clk_gate_pkg::*;

   // ****************************************************************
   // Signals
   // ****************************************************************
   logic                 mclk_in;
   logic                 reset_n_in;
   reg_req_s             reg_req_in;
   logic [DATA_W-1:0]    reg_rdata_out;
   logic                 sleep_in;
   logic                 deep_sleep_in;
   periph_access_s       periph_access_in;
   logic                 periph_fault_out;
   logic [UNIT_CNT-1:0]  unit_clk_en_out;
   logic                 irq_out;
   int                   num_errors;
   int                   comparisons;

   // Design under test.
   periph_clock_gating uut (
      .mclk_in          (mclk_in),
      .reset_n_in       (reset_n_in),
      .reg_req_in       (reg_req_in),
      .reg_rdata_out    (reg_rdata_out),
      .sleep_in         (sleep_in),
      .deep_sleep_in    (deep_sleep_in),
      .periph_access_in (periph_access_in),
      .periph_fault_out (periph_fault_out),
      .unit_clk_en_out  (unit_clk_en_out),
      .irq_out          (irq_out)
   );

   // The clock toggles every 20 ns, half of its 40 ns period.
   always #20 mclk_in = ~mclk_in;

   // ****************************************************************
   // Helper tasks
   // ****************************************************************
   // Compares one value and reports a mismatch at once.
   task automatic check(input string name, input logic [31:0] exp,
                        input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Lets a number of rising edges pass, then steps past the updates.
   task automatic wait_cycles(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask

   // One-cycle register write.
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      reg_req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_in);
      reg_req_in <= '0;
   endtask

   // One-cycle register read; the data stand in the following cycle.
   task automatic rd_check(input string name, input logic [11:0] a,
                           input logic [31:0] exp);
      @(posedge mclk_in);
      reg_req_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_in);
      reg_req_in <= '0;
      #1;
      check(name, exp, reg_rdata_out);
   endtask

   // One peripheral access; the fault answer stands one cycle later.
   task automatic access(input logic [2:0] u, input logic exp);
      @(posedge mclk_in);
      periph_access_in <= '{valid: 1'b1, unit: u};
      @(posedge mclk_in);
      periph_access_in <= '0;
      #1;
      check("periph_fault_out", {31'h0, exp}, {31'h0, periph_fault_out});
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Reset values of the gating registers and of the enables.
   task automatic test_reset_values();
      wait_cycles(2);
      check("enables after reset", 32'h2, {25'h0, unit_clk_en_out});
      rd_check("run one reset", 12'h104, 32'h0000_0000);
      rd_check("deep zero reset", 12'h120, 32'h0000_0040);
      rd_check("run zero reset", 12'h100, 32'h0000_0040);
      rd_check("sleep zero reset", 12'h110, 32'h0000_0040);
      rd_check("sleep one reset", 12'h114, 32'h0000_0000);
      rd_check("deep one reset", 12'h124, 32'h0000_0000);
      rd_check("select reset", 12'h140, 32'h0000_0000);
   endtask

   // All-ones writes keep only the gate bits; reserved bits stay zero.
   task automatic test_field_masks();
      wr_reg(12'h104, 32'hffff_ffff);
      rd_check("run one ones", 12'h104, 32'h000f_0000);
      wr_reg(12'h120, 32'hffff_ffff);
      rd_check("deep zero ones", 12'h120, 32'h0100_0048);
      wr_reg(12'h120, 32'hfeff_ffb7);
      rd_check("deep zero inverse", 12'h120, 32'h0);
   endtask

   // Each timer gate drives its own enable, and clearing stops it.
   task automatic test_timer_gates();
      for (int i = 0; i < 4; i++) begin
         wr_reg(12'h104, 32'h1 << (16 + i));
         wait_cycles(2);
         check("timer enable", 32'h2 | (32'h8 << i),
               {25'h0, unit_clk_en_out});
      end
      wr_reg(12'h100, 32'h0100_0048);
      wait_cycles(2);
      check("zero reg enables", 32'h47, {25'h0, unit_clk_en_out});
      wr_reg(12'h104, 32'h0);
      wr_reg(12'h100, 32'h0);
      wait_cycles(2);
      check("all gated", 32'h0, {25'h0, unit_clk_en_out});
   endtask

   // Gated units fault, clocked units do not, and faults raise irq.
   task automatic test_faults_irq();
      wr_reg(12'h144, 32'h3);
      wr_reg(12'h148, 32'h1);
      access(3'h2, 1'b1);
      wait_cycles(1);
      check("irq after fault", 32'h1, {31'h0, irq_out});
      rd_check("status fault", 12'h144, 32'h1);
      wr_reg(12'h144, 32'h1);
      wait_cycles(2);
      check("irq cleared", 32'h0, {31'h0, irq_out});
      // Software enables the watchdog and timer zero before use.
      wr_reg(12'h100, 32'h0000_0008);
      wr_reg(12'h104, 32'h0001_0000);
      wait_cycles(2);
      access(3'h2, 1'b0);
      access(3'h3, 1'b0);
      access(3'h4, 1'b1);
      access(3'h0, 1'b1);
      access(3'h7, 1'b1);
      rd_check("last fault unit", 12'h14c, 32'h7);
      wr_reg(12'h148, 32'h0);
      wait_cycles(2);
      check("masked irq", 32'h0, {31'h0, irq_out});
      wr_reg(12'h144, 32'h3);
      rd_check("unmapped read", 12'h1f0, 32'h0);
      rd_check("status unmapped", 12'h144, 32'h2);
   endtask

   // Deep sleep without automatic selection keeps the run set; with it, each mode uses its own set.
   task automatic test_modes();
      wr_reg(12'h120, 32'h0100_0000);
      wr_reg(12'h110, 32'h0000_0008);
      wr_reg(12'h124, 32'h0008_0000);
      wr_reg(12'h114, 32'h0004_0000);
      @(posedge mclk_in);
      deep_sleep_in <= 1'b1;
      wait_cycles(3);
      check("deep no select", 32'hc, {25'h0, unit_clk_en_out});
      wr_reg(12'h140, 32'h1);
      rd_check("auto select", 12'h140, 32'h1);
      wait_cycles(3);
      check("deep set", 32'h41, {25'h0, unit_clk_en_out});
      @(posedge mclk_in);
      deep_sleep_in <= 1'b0;
      sleep_in      <= 1'b1;
      wait_cycles(3);
      check("sleep set", 32'h24, {25'h0, unit_clk_en_out});
      @(posedge mclk_in);
      sleep_in <= 1'b0;
      wait_cycles(3);
      check("run set", 32'hc, {25'h0, unit_clk_en_out});
   endtask

   // ****************************************************************
   // Verdict and main sequence
   // ****************************************************************
   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Drives reset, then runs every scenario in turn.
   initial begin
      mclk_in          = 1'b0;
      reset_n_in       = 1'b0;
      reg_req_in       = '0;
      sleep_in         = 1'b0;
      deep_sleep_in    = 1'b0;
      periph_access_in = '0;
      num_errors       = 0;
      comparisons      = 0;
      repeat (12) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      test_reset_values();
      test_field_masks();
      test_timer_gates();
      test_faults_irq();
      test_modes();
      test_done();
   end

   // Cuts a hang short well after the scenarios should have ended.
   initial begin
      #(40 * 5000);
      num_errors++;
      test_done();
   end

endmodule // periph_clock_gating_tb_top
